// [rtl/dmx_pkg.sv]
package dmx_pkg;

	// ********************
	// Widths
	// ********************
	localparam int SPEED_W = 16;
	localparam int POS_W   = 32;
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;

	// ********************
	// Register map
	// ********************
	localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_ISTAT  = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_IMASK  = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_SPEED  = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_POS    = 8'h14;

	// Control fields
	localparam int CTRL_W        = 6;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MODE_W   = 2;
	localparam int CTRL_INH_EN   = 2;
	localparam int CTRL_RST_EN   = 3;
	localparam int CTRL_ABS      = 4;
	localparam int CTRL_LIN      = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h02;

	// Status fields
	localparam int ST_SUPERV = 0;
	localparam int ST_VALID  = 1;
	localparam int ST_STILL  = 2;
	localparam int ST_W      = 3;

	// Interrupt fields
	localparam int IRQ_ERR = 0;
	localparam int IRQ_CLR = 1;
	localparam int IRQ_W   = 2;

	// ********************
	// Timing and thresholds
	// ********************
	localparam int unsigned STILL_MS  = 1000;
	localparam int unsigned CLK_HZ    = 40_000_000;
	localparam int unsigned STILL_CYC = STILL_MS * (CLK_HZ / 1000);

	localparam int ROT_STILL_RPM  = 40;
	localparam int DIGITS_PER_RPM = 2;
	localparam int LIN_STILL_MMS  = 80;
	localparam int DIGITS_PER_MMS = 1;
	localparam logic [SPEED_W-1:0] ROT_STILL_DIG = SPEED_W'(ROT_STILL_RPM * DIGITS_PER_RPM);
	localparam logic [SPEED_W-1:0] LIN_STILL_DIG = SPEED_W'(LIN_STILL_MMS * DIGITS_PER_MMS);

	// ********************
	// Types
	// ********************
	typedef enum logic [1:0] {DMX_MODE_IN1, DMX_MODE_HIGH, DMX_MODE_MEAN} dmx_mode_t;
	typedef enum logic {DMX_OK, DMX_ERR} dmx_state_t;

endpackage

// [rtl/dmx_mix_if.sv]
`timescale 1ns/10ps
interface dmx_mix_if #(
	parameter int SW = 16,
	parameter int PW = 32
);
	logic [1:0]           mode;
	logic signed [SW-1:0] speed1;
	logic signed [SW-1:0] speed2;
	logic signed [SW-1:0] speed_out;
	logic signed [PW-1:0] delta1;
	logic signed [PW-1:0] delta2;
	logic signed [PW-1:0] delta_out;

	modport src (output mode, speed1, speed2, delta1, delta2, input speed_out, delta_out);
	modport mix (input mode, speed1, speed2, delta1, delta2, output speed_out, delta_out);
endinterface

// [rtl/dmx_mix.sv]
`timescale 1ns/10ps
module dmx_mix #(
	parameter int SW = 16,
	parameter int PW = 32
) (
	dmx_mix_if.mix mx
);
	logic signed [SW:0] s_sum;
	logic signed [SW:0] s_tmp;
	logic signed [PW:0] d_sum;
	logic signed [PW:0] d_tmp;
	logic [SW:0]        mag1;
	logic [SW:0]        mag2;
	logic [PW:0]        dmag1;
	logic [PW:0]        dmag2;

	// ********************
	// Averages and selection
	// ********************
	always_comb begin
		s_sum = {mx.speed1[SW-1], mx.speed1} + {mx.speed2[SW-1], mx.speed2};
		s_tmp = s_sum + {{SW{1'b0}}, s_sum[SW]};
		d_sum = {mx.delta1[PW-1], mx.delta1} + {mx.delta2[PW-1], mx.delta2};
		d_tmp = d_sum + {{PW{1'b0}}, d_sum[PW]};
		mag1  = mx.speed1[SW-1] ? -{1'b1, mx.speed1} : {1'b0, mx.speed1};
		mag2  = mx.speed2[SW-1] ? -{1'b1, mx.speed2} : {1'b0, mx.speed2};
		dmag1 = mx.delta1[PW-1] ? -{1'b1, mx.delta1} : {1'b0, mx.delta1};
		dmag2 = mx.delta2[PW-1] ? -{1'b1, mx.delta2} : {1'b0, mx.delta2};
		unique case (mx.mode)
			dmx_pkg::DMX_MODE_IN1: begin
				mx.speed_out = mx.speed1;
				mx.delta_out = mx.delta1;
			end
			dmx_pkg::DMX_MODE_HIGH: begin
				mx.speed_out = (mag1 >= mag2) ? mx.speed1 : mx.speed2;
				mx.delta_out = (dmag1 >= dmag2) ? mx.delta1 : mx.delta2;
			end
			default: begin
				mx.speed_out = s_tmp[SW:1];
				mx.delta_out = d_tmp[PW:1];
			end
		endcase
	end
endmodule // dmx_mix

// [rtl/dmx_still.sv]
`timescale 1ns/10ps
module dmx_still #(
	parameter int unsigned HOLD = dmx_pkg::STILL_CYC,
	parameter int          SW   = 16
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic signed [SW-1:0] speed,
	input  wire logic                 speed_ok,
	input  wire logic                 linear,
	output logic                      near,
	output logic                      still_ok
);
	localparam int CW = $clog2(HOLD + 1);
	localparam logic [CW-1:0] HOLD_C = CW'(HOLD);

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic [SW-1:0] mag;
	logic [SW-1:0] thr;

	// ********************
	// Standstill timer
	// ********************
	always_comb begin
		mag  = speed[SW-1] ? SW'(-speed) : speed;
		thr  = linear ? dmx_pkg::LIN_STILL_DIG : dmx_pkg::ROT_STILL_DIG;
		near = speed_ok && (mag < thr);
		if (!near) begin
			next_cnt = '0;
		end else if (cnt == HOLD_C) begin
			next_cnt = cnt;
		end else begin
			next_cnt = cnt + CW'(1);
		end
		still_ok = (cnt == HOLD_C);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end
endmodule // dmx_still

// [rtl/dmx_mean_chk.sv]
// Behaviour
// - Mean mode outputs signed average of both input speeds.
// - Mean mode adds average of both position deltas to previous output.
// - Failed cross check without suppression marks combined output invalid.
// - With suppression active, failure drops flag but keeps output valid.
// - Supervision flag returns to one only after error is cleared.
// - Reset edge clears error if first speed still one second and ratio ok.
// - Near zero means below 40 rpm rotary or 80 mm/s linear.
// - Automatic clear while suppression is one and difference is within limit.
// - Optional: automatic clear also needs speed above the speed at detection.
// - Without suppression or reset input, error stays latched for good.
// - Any invalid input speed makes combined output invalid.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module dmx_mean_chk #(
	parameter int          SPEED_W    = dmx_pkg::SPEED_W,
	parameter int          POS_W      = dmx_pkg::POS_W,
	parameter int unsigned STILL_HOLD = dmx_pkg::STILL_CYC
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [dmx_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [dmx_pkg::DATA_W-1:0]  pwdata,
	output logic      [dmx_pkg::DATA_W-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        cyc,
	input  wire logic signed [SPEED_W-1:0]   speed1,
	input  wire logic                        speed1_valid,
	input  wire logic signed [POS_W-1:0]     pos1,
	input  wire logic signed [SPEED_W-1:0]   speed2,
	input  wire logic                        speed2_valid,
	input  wire logic signed [POS_W-1:0]     pos2,
	input  wire logic                        xchk_fail,
	input  wire logic                        ratio_ok,
	input  wire logic                        diff_ok,
	input  wire logic                        inhibit_in,
	input  wire logic                        reset_in,
	output logic signed [SPEED_W-1:0]        out_speed,
	output logic signed [POS_W-1:0]          out_pos,
	output logic                             out_valid,
	output logic                             superv,
	output logic                             irq
);
	// ********************
	// Declarations
	// ********************
	logic [dmx_pkg::CTRL_W-1:0] ctrl;
	logic [dmx_pkg::CTRL_W-1:0] next_ctrl;
	logic [dmx_pkg::IRQ_W-1:0]  istat;
	logic [dmx_pkg::IRQ_W-1:0]  next_istat;
	logic [dmx_pkg::IRQ_W-1:0]  imask;
	logic [dmx_pkg::IRQ_W-1:0]  next_imask;
	logic [dmx_pkg::DATA_W-1:0] next_prdata;
	dmx_pkg::dmx_state_t        err_st;
	dmx_pkg::dmx_state_t        next_err_st;
	logic [SPEED_W-1:0]         cap;
	logic [SPEED_W-1:0]         next_cap;
	logic signed [POS_W-1:0]    prev1;
	logic signed [POS_W-1:0]    next_prev1;
	logic signed [POS_W-1:0]    prev2;
	logic signed [POS_W-1:0]    next_prev2;
	logic                       primed;
	logic                       next_primed;
	logic                       rst_d;
	logic                       next_rst_d;
	logic signed [SPEED_W-1:0]  next_out_speed;
	logic signed [POS_W-1:0]    next_out_pos;
	logic                       next_out_valid;
	logic                       both_ok;
	logic                       fail;
	logic                       inh_act;
	logic                       clear_man;
	logic                       clear_auto;
	logic                       ev_set;
	logic                       ev_clr;
	logic [SPEED_W-1:0]         abs_now;
	logic                       near;
	logic                       still_ok;
	logic                       wr_acc;
	logic                       rd_setup;
	logic                       mapped;
	logic [dmx_pkg::IRQ_W-1:0]  w1c;

	dmx_mix_if #(.SW(SPEED_W), .PW(POS_W)) mx ();

	// ********************
	// Submodules
	// ********************
	dmx_mix #(.SW(SPEED_W), .PW(POS_W)) u_mix (
		.mx (mx.mix)
	);

	dmx_still #(.HOLD(STILL_HOLD), .SW(SPEED_W)) u_still (
		.pclk     (pclk),
		.presetn  (presetn),
		.speed    (speed1),
		.speed_ok (speed1_valid),
		.linear   (ctrl[dmx_pkg::CTRL_LIN]),
		.near     (near),
		.still_ok (still_ok)
	);

	assign mx.mode   = ctrl[dmx_pkg::CTRL_MODE_LSB +: dmx_pkg::CTRL_MODE_W];
	assign mx.speed1 = speed1;
	assign mx.speed2 = speed2;
	assign mx.delta1 = primed ? POS_W'(pos1 - prev1) : '0;
	assign mx.delta2 = primed ? POS_W'(pos2 - prev2) : '0;

	// ********************
	// Error and motion output
	// ********************
	always_comb begin
		both_ok    = speed1_valid && speed2_valid;
		fail       = cyc && xchk_fail;
		inh_act    = ctrl[dmx_pkg::CTRL_INH_EN] && inhibit_in;
		abs_now    = mx.speed_out[SPEED_W-1] ? SPEED_W'(-mx.speed_out) : mx.speed_out;
		clear_man  = (err_st == dmx_pkg::DMX_ERR) && ctrl[dmx_pkg::CTRL_RST_EN]
			&& reset_in && !rst_d && still_ok && ratio_ok;
		clear_auto = (err_st == dmx_pkg::DMX_ERR) && inh_act && diff_ok
			&& (!ctrl[dmx_pkg::CTRL_ABS] || (abs_now > cap));
		ev_set     = fail && (err_st == dmx_pkg::DMX_OK);
		ev_clr     = (clear_man || clear_auto) && !fail;
		next_rst_d = reset_in;
		next_cap   = ev_set ? abs_now : cap;
		if (fail) begin
			next_err_st = dmx_pkg::DMX_ERR;
		end else if (clear_man || clear_auto) begin
			next_err_st = dmx_pkg::DMX_OK;
		end else begin
			next_err_st = err_st;
		end
		next_prev1     = prev1;
		next_prev2     = prev2;
		next_primed    = primed;
		next_out_speed = out_speed;
		next_out_pos   = out_pos;
		next_out_valid = out_valid;
		if (cyc) begin
			next_prev1     = pos1;
			next_prev2     = pos2;
			next_primed    = 1'b1;
			next_out_valid = both_ok && !((next_err_st == dmx_pkg::DMX_ERR) && !inh_act);
			if (both_ok) begin
				next_out_speed = mx.speed_out;
				next_out_pos   = POS_W'(out_pos + mx.delta_out);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_st    <= dmx_pkg::DMX_OK;
			cap       <= '0;
			prev1     <= '0;
			prev2     <= '0;
			primed    <= 1'b0;
			rst_d     <= 1'b0;
			out_speed <= '0;
			out_pos   <= '0;
			out_valid <= 1'b0;
		end else begin
			err_st    <= next_err_st;
			cap       <= next_cap;
			prev1     <= next_prev1;
			prev2     <= next_prev2;
			primed    <= next_primed;
			rst_d     <= next_rst_d;
			out_speed <= next_out_speed;
			out_pos   <= next_out_pos;
			out_valid <= next_out_valid;
		end
	end

	assign superv = (err_st == dmx_pkg::DMX_OK);
	assign irq    = |(istat & imask);

	// ********************
	// APB slave
	// ********************
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		wr_acc   = psel && penable && pwrite;
		rd_setup = psel && !penable && !pwrite;
		mapped   = (paddr == dmx_pkg::ADDR_CTRL) || (paddr == dmx_pkg::ADDR_STATUS)
			|| (paddr == dmx_pkg::ADDR_ISTAT) || (paddr == dmx_pkg::ADDR_IMASK)
			|| (paddr == dmx_pkg::ADDR_SPEED) || (paddr == dmx_pkg::ADDR_POS);
		next_ctrl  = ctrl;
		next_imask = imask;
		w1c        = '0;
		if (wr_acc && (paddr == dmx_pkg::ADDR_CTRL)) begin
			next_ctrl = pwdata[dmx_pkg::CTRL_W-1:0];
		end
		if (wr_acc && (paddr == dmx_pkg::ADDR_IMASK)) begin
			next_imask = pwdata[dmx_pkg::IRQ_W-1:0];
		end
		if (wr_acc && (paddr == dmx_pkg::ADDR_ISTAT)) begin
			w1c = pwdata[dmx_pkg::IRQ_W-1:0];
		end
		next_istat = istat & ~w1c;
		next_istat[dmx_pkg::IRQ_ERR] = next_istat[dmx_pkg::IRQ_ERR] | ev_set;
		next_istat[dmx_pkg::IRQ_CLR] = next_istat[dmx_pkg::IRQ_CLR] | ev_clr;
		next_prdata = prdata;
		if (rd_setup) begin
			unique case (paddr)
				dmx_pkg::ADDR_CTRL:   next_prdata = {{(dmx_pkg::DATA_W-dmx_pkg::CTRL_W){1'b0}}, ctrl};
				dmx_pkg::ADDR_STATUS: next_prdata = {{(dmx_pkg::DATA_W-dmx_pkg::ST_W){1'b0}},
					still_ok, out_valid, superv};
				dmx_pkg::ADDR_ISTAT:  next_prdata = {{(dmx_pkg::DATA_W-dmx_pkg::IRQ_W){1'b0}}, istat};
				dmx_pkg::ADDR_IMASK:  next_prdata = {{(dmx_pkg::DATA_W-dmx_pkg::IRQ_W){1'b0}}, imask};
				dmx_pkg::ADDR_SPEED:  next_prdata = dmx_pkg::DATA_W'(out_speed);
				dmx_pkg::ADDR_POS:    next_prdata = dmx_pkg::DATA_W'(out_pos);
				default:              next_prdata = '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl   <= dmx_pkg::CTRL_RESET;
			istat  <= '0;
			imask  <= '0;
			prdata <= '0;
		end else begin
			ctrl   <= next_ctrl;
			istat  <= next_istat;
			imask  <= next_imask;
			prdata <= next_prdata;
		end
	end

	// ********************
	// Checks
	// ********************
	logic signed [SPEED_W:0]   chk_avg;
	logic signed [SPEED_W-1:0] chk_avg_lo;
	logic signed [POS_W:0]     chk_dlt;
	logic signed [POS_W-1:0]   chk_dlt_lo;
	logic                      mean_mode;
	logic signed [POS_W-1:0]   ref_prev1;
	logic signed [POS_W-1:0]   next_ref_prev1;
	logic signed [POS_W-1:0]   ref_prev2;
	logic signed [POS_W-1:0]   next_ref_prev2;
	logic                      ref_primed;
	logic                      next_ref_primed;
	logic signed [POS_W-1:0]   ref_d1;
	logic signed [POS_W-1:0]   ref_d2;

	always_comb begin
		next_ref_prev1  = ref_prev1;
		next_ref_prev2  = ref_prev2;
		next_ref_primed = ref_primed;
		if (cyc) begin
			next_ref_prev1  = pos1;
			next_ref_prev2  = pos2;
			next_ref_primed = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_prev1  <= '0;
			ref_prev2  <= '0;
			ref_primed <= 1'b0;
		end else begin
			ref_prev1  <= next_ref_prev1;
			ref_prev2  <= next_ref_prev2;
			ref_primed <= next_ref_primed;
		end
	end

	assign ref_d1     = ref_primed ? POS_W'(pos1 - ref_prev1) : '0;
	assign ref_d2     = ref_primed ? POS_W'(pos2 - ref_prev2) : '0;
	assign chk_avg    = (SPEED_W+1)'(($signed({speed1[SPEED_W-1], speed1})
		+ $signed({speed2[SPEED_W-1], speed2})) / 2);
	assign chk_avg_lo = chk_avg[SPEED_W-1:0];
	assign chk_dlt    = (POS_W+1)'(($signed({ref_d1[POS_W-1], ref_d1})
		+ $signed({ref_d2[POS_W-1], ref_d2})) / 2);
	assign chk_dlt_lo = chk_dlt[POS_W-1:0];
	assign mean_mode  = (mx.mode == dmx_pkg::DMX_MODE_MEAN);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	mean_speed_a: assert property (cyc && mean_mode && both_ok
		|=> out_speed == $past(chk_avg_lo))
		else $error("mean speed wrong");
	pos_accum_a: assert property (cyc && mean_mode && both_ok
		|=> out_pos == $past(out_pos) + $past(chk_dlt_lo))
		else $error("mean position wrong");
	err_invalid_a: assert property (fail && !inh_act
		|=> !out_valid && !superv)
		else $error("error did not invalidate output");
	err_latch_a: assert property (!superv && !inh_act && !clear_man && cyc
		|=> !out_valid)
		else $error("output valid during error");
	err_flag_a: assert property (fail && superv |=> istat[dmx_pkg::IRQ_ERR])
		else $error("error event not flagged");
	inhibit_keep_a: assert property (fail && inh_act && both_ok
		|=> out_valid && !superv)
		else $error("suppressed error changed output");
	flag_return_a: assert property ($rose(superv) |-> $past(clear_man || clear_auto))
		else $error("flag returned without clear");
	clr_flag_a: assert property ($rose(superv) |-> istat[dmx_pkg::IRQ_CLR])
		else $error("clear event not flagged");
	fail_wins_a: assert property (fail |=> !superv)
		else $error("clear won over failure");
	man_clear_a: assert property (!superv && ctrl[dmx_pkg::CTRL_RST_EN] && !fail
		&& reset_in && !rst_d && still_ok && ratio_ok |=> superv)
		else $error("manual clear missed");
	man_block_a: assert property (!superv && !inh_act && !(still_ok && ratio_ok)
		|=> !superv)
		else $error("manual clear without conditions");
	still_hold_a: assert property (still_ok |-> $past(near))
		else $error("standstill without near speed");
	still_near_a: assert property (!near |=> !still_ok)
		else $error("standstill held while moving");
	auto_clear_a: assert property (!superv && inh_act && diff_ok
		&& !ctrl[dmx_pkg::CTRL_ABS] && !fail |=> superv)
		else $error("automatic clear missed");
	abs_gate_a: assert property (!superv && !clear_man && ctrl[dmx_pkg::CTRL_ABS]
		&& (abs_now <= cap) |=> !superv)
		else $error("automatic clear below detection speed");
	latch_keep_a: assert property (!superv && !ctrl[dmx_pkg::CTRL_INH_EN]
		&& !ctrl[dmx_pkg::CTRL_RST_EN] |=> !superv)
		else $error("latched error cleared");
	invalid_in_a: assert property (cyc && !both_ok |=> !out_valid)
		else $error("invalid input passed");
	hold_invalid_a: assert property (cyc && !both_ok
		|=> out_speed == $past(out_speed) && out_pos == $past(out_pos))
		else $error("invalid input moved output");

	err_seen_c: cover property (fail ##1 !superv);
	inh_keep_c: cover property (fail && inh_act ##1 out_valid);
	man_clear_c: cover property (clear_man ##1 superv);
	auto_clear_c: cover property (clear_auto ##1 superv);
	irq_fire_c: cover property (irq);
endmodule // dmx_mean_chk

// [testbench/dmx_enc_model.sv]
`timescale 1ns/10ps
// ********************
// Encoder pair model
// ********************
module dmx_enc_model (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               go,
	input  wire logic signed [15:0] cmd1,
	input  wire logic signed [15:0] cmd2,
	input  wire logic               ok1,
	input  wire logic               ok2,
	output logic                    cyc,
	output logic signed [15:0]      speed1,
	output logic signed [15:0]      speed2,
	output logic                    v1,
	output logic                    v2,
	output logic signed [31:0]      pos1,
	output logic signed [31:0]      pos2,
	output logic                    still
);
	// Standstill per encoder, joined by AND
	assign still = (speed1 < 80) && (speed1 > -80) && (speed2 < 80) && (speed2 > -80);

	// One logic cycle per go; invalid speed shows inverted value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc <= 1'b0;
			speed1 <= 16'sh0;
			speed2 <= 16'sh0;
			v1 <= 1'b0;
			v2 <= 1'b0;
			pos1 <= 32'sh0;
			pos2 <= 32'sh0;
		end else begin
			cyc <= go;
			if (go) begin
				speed1 <= ok1 ? cmd1 : ~cmd1;
				speed2 <= ok2 ? cmd2 : ~cmd2;
				v1 <= ok1;
				v2 <= ok2;
				pos1 <= pos1 + 32'(cmd1);
				pos2 <= pos2 + 32'(cmd2);
			end
		end
	end
endmodule // dmx_enc_model

// [testbench/dual_encoder_mean_and_error_reset_tb.sv]
`timescale 1ns/10ps
module dual_encoder_mean_and_error_reset_tb;
	localparam int HOLD = 20;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rd;
	logic               cyc, v1, v2, go, ok1, ok2, xchk_fail, ratio_ok, diff_ok;
	logic               inhibit_in, reset_in, out_valid, superv, irq, still_both;
	logic signed [15:0] speed1, speed2, cmd1, cmd2, out_speed, a, b;
	logic signed [31:0] pos1, pos2, out_pos;
	logic [15:0]        lf;
	int                 err_total, n_compared, tick, e_spd, e_pos, p1, p2, q1, q2;

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	dmx_enc_model dmx_enc_model_inst (.pclk(pclk), .presetn(presetn), .go(go), .cmd1(cmd1),
		.cmd2(cmd2), .ok1(ok1), .ok2(ok2), .cyc(cyc), .speed1(speed1), .speed2(speed2),
		.v1(v1), .v2(v2), .pos1(pos1), .pos2(pos2), .still(still_both));

	dmx_mean_chk #(.STILL_HOLD(HOLD)) dmx_mean_chk_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cyc(cyc), .speed1(speed1),
		.speed1_valid(v1), .pos1(pos1), .speed2(speed2), .speed2_valid(v2), .pos2(pos2),
		.xchk_fail(xchk_fail), .ratio_ok(ratio_ok), .diff_ok(diff_ok),
		.inhibit_in(inhibit_in), .reset_in(reset_in), .out_speed(out_speed),
		.out_pos(out_pos), .out_valid(out_valid), .superv(superv), .irq(irq));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("compares=%0d mismatches=%0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic step(input logic signed [15:0] x, input logic signed [15:0] y, input logic f);
		@(posedge pclk);
		cmd1 <= x;
		cmd2 <= y;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		xchk_fail <= f;
		@(posedge pclk);
		xchk_fail <= 1'b0;
		#1;
	endtask

	task automatic pulse;
		@(posedge pclk);
		reset_in <= 1'b1;
		repeat (2) @(posedge pclk);
		reset_in <= 1'b0;
		@(posedge pclk);
		#1;
	endtask

	// Hang guard
	always @(posedge pclk) begin
		tick++;
		if (tick == 4000) begin
			err_total++;
			end_sim();
		end
	end

	initial begin
		{psel, penable, pwrite, go, xchk_fail, diff_ok, inhibit_in, reset_in} = '0;
		{paddr, pwdata, cmd1, cmd2} = '0;
		{ok1, ok2, ratio_ok} = 3'h7;
		{err_total, n_compared, tick, e_pos, p1, p2, q1, q2} = '0;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// ********************
		// Reset values
		// ********************
		apb(1'b0, dmx_pkg::ADDR_CTRL, 32'h0);
		chk(rd, 32'h2);
		apb(1'b0, dmx_pkg::ADDR_STATUS, 32'h0);
		chk(rd, 32'h1);
		chk(32'(irq), 32'h0);
		// ********************
		// Mean mode, random stream
		// ********************
		lf = 16'h0009;
		for (int i = 0; i < 24; i++) begin
			if (i == 12)
				apb(1'b1, dmx_pkg::ADDR_CTRL, 32'h3);
			lf = lfsr(lf);
			a = (i == 0) ? -16'sd3 : (i == 1) ? 16'sh7FFF : lf;
			lf = lfsr(lf);
			b = (i == 0) ? 16'sd0 : (i == 1) ? 16'sh7FFF : lf;
			step(a, b, 1'b0);
			p1 = p1 + int'(a);
			p2 = p2 + int'(b);
			if (i > 0)
				e_pos = e_pos + ((p1 - q1) + (p2 - q2)) / 2;
			q1 = p1;
			q2 = p2;
			e_spd = (int'(a) + int'(b)) / 2;
			chk(32'(out_speed), 32'(e_spd));
			chk(32'(out_pos), 32'(e_pos));
			chk(32'(out_valid), 32'h1);
		end
		ok2 <= 1'b0;
		step(16'sd5, 16'sd7, 1'b0);
		chk(32'(out_valid), 32'h0);
		chk(32'(out_speed), 32'(e_spd));
		ok2 <= 1'b1;
		// ********************
		// Error, interrupt, latch
		// ********************
		apb(1'b1, dmx_pkg::ADDR_IMASK, 32'h1);
		step(16'sd10, 16'sd20, 1'b1);
		chk(32'({superv, out_valid, irq}), 32'h1);
		apb(1'b0, dmx_pkg::ADDR_ISTAT, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, dmx_pkg::ADDR_ISTAT, 32'h1);
		chk(32'(irq), 32'h0);
		inhibit_in <= 1'b1;
		diff_ok <= 1'b1;
		step(16'sd0, 16'sd0, 1'b0);
		pulse();
		repeat (HOLD) @(posedge pclk);
		pulse();
		#1;
		chk(32'(superv), 32'h0);
		inhibit_in <= 1'b0;
		diff_ok <= 1'b0;
		// ********************
		// Manual clear, rotary and linear
		// ********************
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, dmx_pkg::ADDR_CTRL, k ? 32'h2A : 32'h0A);
			step(16'sd0, 16'sd0, 1'b1);
			chk(32'(superv), 32'h0);
			step(16'sd80, 16'sd80, 1'b0);
			chk(32'(still_both), 32'h0);
			repeat (HOLD + 4) @(posedge pclk);
			pulse();
			chk(32'(superv), 32'h0);
			step(-16'sd79, 16'sd0, 1'b0);
			chk(32'(still_both), 32'h1);
			repeat (4) @(posedge pclk);
			pulse();
			chk(32'(superv), 32'h0);
			repeat (HOLD) @(posedge pclk);
			ratio_ok <= 1'b0;
			pulse();
			chk(32'(superv), 32'h0);
			ratio_ok <= 1'b1;
			pulse();
			chk(32'(superv), 32'h1);
			apb(1'b0, dmx_pkg::ADDR_STATUS, 32'h0);
			chk(rd, 32'h5);
		end
		apb(1'b1, dmx_pkg::ADDR_ISTAT, 32'h1);
		chk(32'(irq), 32'h0);
		apb(1'b0, dmx_pkg::ADDR_ISTAT, 32'h0);
		chk(rd, 32'h2);
		apb(1'b1, dmx_pkg::ADDR_IMASK, 32'h3);
		chk(32'(irq), 32'h1);
		apb(1'b1, dmx_pkg::ADDR_ISTAT, 32'h2);
		chk(32'(irq), 32'h0);
		// ********************
		// Suppression and automatic clear
		// ********************
		apb(1'b1, dmx_pkg::ADDR_CTRL, 32'h06);
		inhibit_in <= 1'b1;
		step(16'sd100, 16'sd100, 1'b1);
		chk(32'({superv, out_valid}), 32'h1);
		chk(32'(out_speed), 32'd100);
		diff_ok <= 1'b1;
		repeat (2) @(posedge pclk);
		#1;
		chk(32'(superv), 32'h1);
		diff_ok <= 1'b0;
		apb(1'b1, dmx_pkg::ADDR_CTRL, 32'h16);
		step(16'sd100, 16'sd100, 1'b1);
		step(16'sd50, 16'sd50, 1'b0);
		diff_ok <= 1'b1;
		repeat (3) @(posedge pclk);
		#1;
		chk(32'(superv), 32'h0);
		step(16'sd200, 16'sd200, 1'b0);
		repeat (2) @(posedge pclk);
		#1;
		chk(32'(superv), 32'h1);
		// ********************
		// Readback and unmapped address
		// ********************
		apb(1'b0, dmx_pkg::ADDR_SPEED, 32'h0);
		chk(rd, 32'd200);
		apb(1'b1, 8'h1C, 32'hFF);
		apb(1'b0, 8'h18, 32'h0);
		chk({rd[29:0], er, pready}, 32'h3);
		apb(1'b0, dmx_pkg::ADDR_CTRL, 32'h0);
		chk(rd, 32'h16);
		// ********************
		// Other output modes
		// ********************
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, dmx_pkg::ADDR_CTRL, 32'(m));
			step(16'sd30, -16'sd50, 1'b0);
			chk(32'(out_speed), m ? 32'hFFFF_FFCE : 32'h0000_001E);
			chk(32'(out_valid), 32'h1);
		end
		end_sim();
	end
endmodule // dual_encoder_mean_and_error_reset_tb
